// *** rfc_assertions.sv ***
// Purpose: port checks for rfc_top
// Assumes: one clock, async reset, clk_en low only while the bus is idle
// Notes: tick gap tracked by a small counter
`timescale 1ns/1ns
module rfc_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic rf_tx_i,
  input wire logic [2:0] gpio_out_i,
  input wire logic [2:0] gpio_oe_i,
  input wire logic [2:0] frontend_pin_o,
  input wire logic [2:0] frontend_pin_oe_o,
  input wire logic high_rate_o,
  input wire logic bit_tick_o,
  input wire logic baseband_reset_o,
  input wire logic mac_reset_o
);
  int gap_reg, gap_next;
  logic vld_reg, vld_next;
  // gap is void across a baseband reset, the tick restarts there
  always_comb begin
    gap_next = bit_tick_o ? 1 : gap_reg + 1;
    vld_next = (bit_tick_o | vld_reg) & ~baseband_reset_o;
  end
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      gap_reg <= 0;
      vld_reg <= 1'b0;
    end else if (clk_en_i) begin
      gap_reg <= gap_next;
      vld_reg <= vld_next;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence bb_hold;
    baseband_reset_o [*5] ##1 !baseband_reset_o;
  endsequence
  answer_next_a: assert property (psel_i && penable_i && !pready_o && clk_en_i |=> pready_o)
    else $error("no ready after access");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  bb_width_a: assert property ($rose(baseband_reset_o) |-> bb_hold)
    else $error("baseband reset width wrong");
  rate_at_reset_a: assert property ($changed(high_rate_o) |-> $rose(baseband_reset_o))
    else $error("rate changed outside baseband reset");
  tick_gap_a: assert property (bit_tick_o && vld_reg && clk_en_i |->
    gap_reg == ($past(high_rate_o) ? rfc_pkg::HIGH_BIT_CYCLES : rfc_pkg::NORMAL_BIT_CYCLES))
    else $error("bit period wrong");
  fe_levels_a: assert property ($past(clk_en_i) && $past(gpio_oe_i) != 3'h7 &&
    frontend_pin_oe_o == 3'h7 |-> frontend_pin_o == ($past(rf_tx_i) ? 3'h3 : 3'h4))
    else $error("front-end levels wrong");
  gpio_pass_a: assert property ($past(clk_en_i) && frontend_pin_oe_o != 3'h7 |->
    frontend_pin_o == $past(gpio_out_i) && frontend_pin_oe_o == $past(gpio_oe_i))
    else $error("gpio path wrong");
  mac_pulse_a: assert property (mac_reset_o |=> !mac_reset_o) else $error("mac reset too long");
endmodule : rfc_assertions
bind rfc_top rfc_assertions rfc_assertions_i (.clock_i, .rst_i, .clk_en_i, .psel_i, .penable_i, .pready_o,
  .pslverr_o, .rf_tx_i, .gpio_out_i, .gpio_oe_i, .frontend_pin_o, .frontend_pin_oe_o, .high_rate_o,
  .bit_tick_o, .baseband_reset_o, .mac_reset_o);

// *** rfc_fe_model.sv ***
// Purpose: external amplifier and switch model on the front-end pins
// Assumes: a part is on only while all three pins are driven
// Notes: none
`timescale 1ns/1ns
module rfc_fe_model (
  input wire logic [2:0] pin_i,
  input wire logic [2:0] oe_i,
  output logic pa_on_o,
  output logic lna_on_o
);
  assign pa_on_o = &oe_i & pin_i[0] & pin_i[1] & ~pin_i[2];
  assign lna_on_o = &oe_i & pin_i[2] & ~pin_i[0] & ~pin_i[1];
endmodule : rfc_fe_model

// *** rfc_pkg.sv ***
// Purpose: constants for the rate and front-end control block
// Assumes: 8-bit registers, one aligned 32-bit apb word each
// Notes: printed offsets are register indexes, byte address is four times
package rfc_pkg;
  // ****************************************
  // register indexes
  // ****************************************
  localparam logic [9:0] IDX_SYMBOL_TICK_HIGH_TX_ON_TIME = 10'h015;
  localparam logic [9:0] IDX_AMP_ON_TIME_LOW = 10'h016;
  localparam logic [9:0] IDX_AMP_ON_TIME_CTL = 10'h017;
  localparam logic [9:0] IDX_TX_ON_TIME_CTL = 10'h018;
  localparam logic [9:0] IDX_SOFT_RESET_CTL = 10'h02a;
  localparam logic [9:0] IDX_RF_STABILIZE_IFS_TIME = 10'h02e;
  localparam logic [9:0] IDX_BASEBAND_CTL_ZERO = 10'h038;
  localparam logic [9:0] IDX_BASEBAND_CTL_THREE = 10'h03b;
  localparam logic [9:0] IDX_BASEBAND_CTL_FOUR = 10'h03c;
  localparam logic [9:0] IDX_FRONTEND_PIN_SELECT = 10'h22f;
  localparam logic [9:0] IDX_RATE_STATUS = 10'h3f0;
  // ****************************************
  // fields and values
  // ****************************************
  localparam int HIGH_RATE_BIT = 0;
  localparam int BASEBAND_RESET_BIT = 1;
  localparam int MAC_RESET_BIT = 0;
  localparam int POWER_RESET_BIT = 2;
  localparam int PREVALID_LSB = 4;
  localparam int CARRIER_SENSE_THRESHOLD_LSB = 5;
  localparam logic [3:0] PREVALID_HIGH_RATE = 4'h3;
  localparam logic [2:0] CARRIER_SENSE_THRESHOLD_HIGH_RATE = 3'h2;
  localparam logic [2:0] PIN_SELECT_FRONTEND = 3'h7;
  localparam logic [7:0] MASK_SOFT_RESET = 8'h07;
  localparam logic [7:0] MASK_BASEBAND_ZERO = 8'h01;
  localparam logic [7:0] MASK_BASEBAND_THREE = 8'hfe;
  localparam logic [7:0] MASK_BASEBAND_FOUR = 8'hfc;
  localparam logic [7:0] MASK_AMP_CTL = 8'h1f;
  localparam logic [7:0] MASK_TX_CTL = 8'hbf;
  localparam logic [7:0] MASK_PIN_SELECT = 8'h1f;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLOCK_MHZ = 250;
  localparam int BASEBAND_RESET_NS = 20;
  localparam int BASEBAND_RESET_CYCLES = (BASEBAND_RESET_NS * CLOCK_MHZ + 999) / 1000;
  localparam int NORMAL_KBPS = 250;
  localparam int HIGH_KBPS = 625;
  localparam int NORMAL_BIT_CYCLES = CLOCK_MHZ * 1000 / NORMAL_KBPS;
  localparam int HIGH_BIT_CYCLES = CLOCK_MHZ * 1000 / HIGH_KBPS;
endpackage : rfc_pkg

// *** rfc_rate_tick.sv ***
// Purpose: bit rate tick generator for normal and high rate
// Assumes: period change takes effect at once, the running count is compared with the new end
// Notes: none
`timescale 1ns/1ns
module rfc_rate_tick #(
  parameter int NORMAL_CYCLES = rfc_pkg::NORMAL_BIT_CYCLES,
  parameter int HIGH_CYCLES = rfc_pkg::HIGH_BIT_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic high_rate_i,
  output logic tick_o
);
  logic [11:0] count_reg;
  logic [11:0] count_next;
  logic tick_next;
  logic [11:0] last;

  always_comb begin
    last = high_rate_i ? 12'(HIGH_CYCLES - 1) : 12'(NORMAL_CYCLES - 1);
    count_next = count_reg + 12'h001;
    tick_next = 1'b0;
    if (clear_i) begin
      count_next = 12'h000;
    end else if (count_reg >= last) begin
      count_next = 12'h000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 12'h000;
      tick_o <= 1'b0;
    end else if (enable_i) begin
      count_reg <= count_next;
      tick_o <= tick_next;
    end
  end
endmodule : rfc_rate_tick

// *** rfc_top.sv ***
// Purpose: high rate mode and external front-end pin control
// Assumes: apb slave, rf state from the radio core as inputs
// Notes: registers are 8 bits in the low byte of each word
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
module rfc_top (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic rf_tx_i,
  input wire logic rf_rx_i,
  input wire logic [2:0] gpio_out_i,
  input wire logic [2:0] gpio_oe_i,
  output logic [2:0] frontend_pin_o,
  output logic [2:0] frontend_pin_oe_o,
  output logic high_rate_o,
  output logic bit_tick_o,
  output logic baseband_reset_o,
  output logic mac_reset_o,
  output logic power_reset_o
);
  // ****************************************
  // register file
  // ****************************************
  logic [7:0] regs_reg [10];
  logic [7:0] regs_next [10];
  logic [7:0] masks [10];
  logic [9:0] idxs [10];
  logic [2:0] strobe_reg;
  logic [2:0] strobe_next;
  logic [31:0] rdata_next;
  logic ready_next;
  logic err_next;
  logic [9:0] widx;
  logic hit;
  logic access;
  logic [3:0] rst_cnt_reg;
  logic [3:0] rst_cnt_next;
  logic [2:0] pin_next;
  logic [2:0] oe_next;
  logic tick;

  assign idxs = '{rfc_pkg::IDX_SYMBOL_TICK_HIGH_TX_ON_TIME, rfc_pkg::IDX_AMP_ON_TIME_LOW,
                  rfc_pkg::IDX_AMP_ON_TIME_CTL, rfc_pkg::IDX_TX_ON_TIME_CTL,
                  rfc_pkg::IDX_SOFT_RESET_CTL, rfc_pkg::IDX_RF_STABILIZE_IFS_TIME,
                  rfc_pkg::IDX_BASEBAND_CTL_ZERO, rfc_pkg::IDX_BASEBAND_CTL_THREE,
                  rfc_pkg::IDX_BASEBAND_CTL_FOUR, rfc_pkg::IDX_FRONTEND_PIN_SELECT};
  assign masks = '{8'hff, 8'hff, rfc_pkg::MASK_AMP_CTL, rfc_pkg::MASK_TX_CTL,
                   8'h00, 8'hff, rfc_pkg::MASK_BASEBAND_ZERO, rfc_pkg::MASK_BASEBAND_THREE,
                   rfc_pkg::MASK_BASEBAND_FOUR, rfc_pkg::MASK_PIN_SELECT};

  // access phase answered in one cycle, pready pulses the cycle after
  assign access = psel_i && penable_i && !pready_o;
  assign widx = paddr_i[11:2];

  always_comb begin
    regs_next = regs_reg;
    rdata_next = 32'h0000_0000;
    ready_next = access;
    err_next = 1'b0;
    hit = 1'b0;
    strobe_next = 3'h0;
    if (access) begin
      for (int i = 0; i < 10; i++) begin
        if (widx == idxs[i]) begin
          hit = 1'b1;
          if (pwrite_i) begin
            regs_next[i] = pwdata_i[7:0] & masks[i];
          end else begin
            rdata_next = {24'h000000, regs_reg[i]};
          end
        end
      end
      if (widx == rfc_pkg::IDX_SOFT_RESET_CTL && pwrite_i) begin
        strobe_next = pwdata_i[2:0] & rfc_pkg::MASK_SOFT_RESET[2:0];
      end
      if (widx == rfc_pkg::IDX_RATE_STATUS) begin
        hit = 1'b1;
        rdata_next = {30'h0000_0000, (rst_cnt_reg != 4'h0), high_rate_o};
      end
      if (widx == rfc_pkg::IDX_SOFT_RESET_CTL && !pwrite_i) begin
        rdata_next = {29'h0000_0000, power_reset_o, baseband_reset_o, mac_reset_o};
      end
      err_next = !hit;
    end
  end

  // ****************************************
  // baseband reset pulse
  // ****************************************
  always_comb begin
    rst_cnt_next = rst_cnt_reg;
    if (strobe_reg[rfc_pkg::BASEBAND_RESET_BIT]) begin
      rst_cnt_next = 4'(rfc_pkg::BASEBAND_RESET_CYCLES);
    end else if (rst_cnt_reg != 4'h0) begin
      rst_cnt_next = rst_cnt_reg - 4'h1;
    end
  end

  // ****************************************
  // front-end pins
  // ****************************************
  always_comb begin
    pin_next = gpio_out_i;
    oe_next = gpio_oe_i;
    if (regs_reg[9][2:0] == rfc_pkg::PIN_SELECT_FRONTEND) begin
      oe_next = 3'h7;
      if (rf_tx_i) begin
        pin_next = 3'b011;
      end else begin
        pin_next = 3'b100;
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 10; i++) begin
        regs_reg[i] <= rfc_pkg::RESET_VALUE;
      end
      strobe_reg <= 3'h0;
      rst_cnt_reg <= 4'h0;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      frontend_pin_o <= 3'h0;
      frontend_pin_oe_o <= 3'h0;
      high_rate_o <= 1'b0;
      baseband_reset_o <= 1'b0;
      mac_reset_o <= 1'b0;
      power_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      regs_reg <= regs_next;
      strobe_reg <= strobe_next;
      rst_cnt_reg <= rst_cnt_next;
      prdata_o <= rdata_next;
      pready_o <= ready_next;
      pslverr_o <= err_next;
      frontend_pin_o <= pin_next;
      frontend_pin_oe_o <= oe_next;
      // rate changes only take effect through the baseband reset
      if (strobe_reg[rfc_pkg::BASEBAND_RESET_BIT]) begin
        high_rate_o <= regs_reg[6][rfc_pkg::HIGH_RATE_BIT];
      end
      baseband_reset_o <= (rst_cnt_next != 4'h0);
      mac_reset_o <= strobe_reg[rfc_pkg::MAC_RESET_BIT];
      power_reset_o <= strobe_reg[rfc_pkg::POWER_RESET_BIT];
    end
  end

  // ****************************************
  // bit rate
  // ****************************************
  rfc_rate_tick u_tick (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .enable_i(clk_en_i),
    .clear_i(baseband_reset_o),
    .high_rate_i(high_rate_o),
    .tick_o(tick)
  );

  always_comb begin
    bit_tick_o = tick;
  end
endmodule : rfc_top

// *** tb_rfc_top.sv ***
// Purpose: self-checking bench for rfc_top
// Assumes: apb master waits for pready
// Notes: bit periods measured on the tick port
`timescale 1ns/1ns
module tb_rfc_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, tx = 1'b0, er;
  logic clk_en = 1'b1;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic pready, perr, hr, tick, bbr, macr, pwrr, pa_on, lna_on;
  logic [2:0] gout = 3'h0, goe = 3'h0, pin, oe;
  int error_cnt = 0, n_compared = 0, n_mac = 0, n_pwr = 0, n;
  always #2 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    n_mac += (macr === 1'b1);
    n_pwr += (pwrr === 1'b1);
  end
  rfc_top rfc_top_i (.clock_i, .rst_i, .clk_en_i(clk_en), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready), .pslverr_o(perr), .rf_tx_i(tx),
    .rf_rx_i(~tx), .gpio_out_i(gout), .gpio_oe_i(goe), .frontend_pin_o(pin), .frontend_pin_oe_o(oe),
    .high_rate_o(hr), .bit_tick_o(tick), .baseband_reset_o(bbr), .mac_reset_o(macr), .power_reset_o(pwrr));
  rfc_fe_model rfc_fe_model_i (.pin_i(pin), .oe_i(oe), .pa_on_o(pa_on), .lna_on_o(lna_on));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // held until pready is sampled high at a rising edge, data taken and request released there
  task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    pa <= {ix, 2'b00};
    pwd <= {24'h0, d};
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic measure();
    n = 0;
    @(negedge clock_i);
    for (int i = 0; i < 3000 && tick !== 1'b1; i++) @(negedge clock_i);
    do begin
      @(negedge clock_i);
      n++;
    end while (tick !== 1'b1 && n < 3000);
  endtask : measure
  task automatic t_regs();
    logic [9:0] ix [9] = '{10'h015, 10'h016, 10'h017, 10'h018, 10'h02e, 10'h038, 10'h03b, 10'h03c, 10'h22f};
    logic [7:0] mk [9] = '{8'hff, 8'hff, 8'h1f, 8'hbf, 8'hff, 8'h01, 8'hfe, 8'hfc, 8'h1f};
    foreach (ix[i]) begin
      apb(1'b0, ix[i], 8'h00);
      chk({er, rd}, 33'h0);
      apb(1'b1, ix[i], 8'hff);
      apb(1'b0, ix[i], 8'h00);
      chk({er, rd}, {9'h0, 16'h0, mk[i]});
    end
    apb(1'b1, 10'h100, 8'hff);
    chk({er, hr}, 2'b10);
    apb(1'b0, 10'h100, 8'h00);
    chk({er, rd}, {1'b1, 32'h0});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_rate();
    measure();
    chk(n, rfc_pkg::NORMAL_BIT_CYCLES);
    apb(1'b1, 10'h038, 8'h01);
    apb(1'b1, 10'h03b, 8'h30);
    apb(1'b1, 10'h03c, 8'h40);
    chk(hr, 1'b0);
    apb(1'b1, 10'h02a, 8'h02);
    @(negedge clock_i);
    chk({bbr, hr}, 2'b11);
    measure();
    chk(n, rfc_pkg::HIGH_BIT_CYCLES);
    apb(1'b0, 10'h3f0, 8'h00);
    chk({er, rd}, 33'h1);
    n = n_mac + n_pwr;
    apb(1'b1, 10'h02a, 8'h05);
    repeat (3) @(posedge clock_i);
    chk(n_mac + n_pwr - n, 2);
    $display("t_rate done");
  endtask : t_rate
  task automatic t_pins();
    logic [7:0] ex;
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, 10'h22f, s[7:0]);
      for (int t = 0; t < 2; t++) begin
        @(posedge clock_i);
        tx <= t[0];
        gout <= ~s[2:0];
        goe <= {1'b0, s[1:0]};
        @(posedge clock_i);
        @(negedge clock_i);
        ex = (s == 7) ? {t[0], ~t[0], 3'h7, 1'b1 ^ t[0], t[0], t[0]} : {2'b00, 1'b0, s[1:0], ~s[2:0]};
        chk({pa_on, lna_on, oe, pin}, ex);
      end
    end
    $display("t_pins done");
  endtask : t_pins
  // clock enable low must freeze tick and pins, then resume
  task automatic t_freeze();
    logic held;
    @(posedge clock_i);
    clk_en <= 1'b0;
    tx <= 1'b0;
    @(negedge clock_i);
    held = tick;
    n = 0;
    repeat (1100) begin
      @(negedge clock_i);
      n += (tick !== held);
    end
    chk(n, 0);
    chk(pin, 3'h3);
    @(posedge clock_i);
    clk_en <= 1'b1;
    @(posedge clock_i);
    @(negedge clock_i);
    chk(pin, 3'h4);
    measure();
    chk(n, rfc_pkg::HIGH_BIT_CYCLES);
    $display("t_freeze done");
  endtask : t_freeze
  task automatic summarize();
    $display("compares %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    t_regs();
    t_rate();
    t_pins();
    t_freeze();
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule : tb_rfc_top
